//--- analyzer_monitor.sv
// Port checker for the trigger capture analyzer
`timescale 1ns/10ps
`default_nettype none
module analyzer_monitor (
    input wire logic                     ref_clk,
    input wire logic                     srst,
    input wire logic                     acquire,
    input wire logic                     read_req,
    input wire analyzer_pkg::sample_type read_data,
    input wire logic                     read_valid,
    input wire logic                     capture_busy,
    input wire logic                     capture_done
);
    import analyzer_pkg::*;
    logic        pend;
    logic        take;
    logic [15:0] busy_cnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // Read taken only when done, idle and none outstanding
    assign take = read_req && capture_done && !capture_busy && !pend;
    // Outstanding read, and cycles spent busy on this capture
    always_ff @(posedge ref_clk) begin
        pend     <= !srst && !read_valid && (pend || take);
        busy_cnt <= (srst || !capture_busy) ? 16'h0000 : busy_cnt + 16'h0001;
    end
    chk_valid_single: assert property (read_valid |=> !read_valid)
        else $error("read_valid held too long");
    chk_acquire_arms:
        assert property (acquire && !capture_busy && !pend |=> capture_busy)
        else $error("acquire not taken");
    chk_finish_done:
        assert property ($fell(capture_busy) |-> capture_done)
        else $error("busy ended without done");
    // 128 samples at the slower link clock never fit in 180 host cycles
    chk_window_length:
        assert property ($fell(capture_busy) |-> busy_cnt >= 16'h00B4)
        else $error("capture window too short");
    chk_read_answer: assert property (take |-> ##[1:30] read_valid)
        else $error("read not answered");
    chk_valid_cause: assert property (read_valid |-> pend)
        else $error("read_valid without request");
    chk_data_stable:
        assert property (!read_valid |-> $stable(read_data))
        else $error("read_data changed without read_valid");
    chk_done_holds:
        assert property (capture_done && !acquire |=> capture_done)
        else $error("capture_done dropped");
    cover property ($rose(capture_done));
    cover property (take);
    cover property (acquire && !capture_busy && !pend);
endmodule : analyzer_monitor

bind trigger_capture_analyzer analyzer_monitor analyzer_monitor_i (
    .ref_clk(ref_clk), .srst(srst), .acquire(acquire),
    .read_req(read_req), .read_data(read_data), .read_valid(read_valid),
    .capture_busy(capture_busy), .capture_done(capture_done));
`default_nettype wire

//--- analyzer_pkg.sv
// Shared constants and types for the trigger capture analyzer
package analyzer_pkg;

    // Channel count and per-channel sample buffer depth
    localparam int CHANNELS = 128;
    localparam int DEPTH    = 128;
    localparam int IDX_W    = 7;
    localparam int COND_W   = 3;

    // Window split around the trigger instant, in percent of the depth
    localparam int POST_PERCENT = 12;
    localparam int POST_COUNT   = DEPTH * POST_PERCENT / 100;
    localparam int PRE_COUNT    = DEPTH - POST_COUNT;

    typedef logic [IDX_W-1:0]                   index_type;
    typedef logic [COND_W-1:0]                  cond_type;
    typedef logic [CHANNELS-1:0]                sample_type;
    typedef logic [CHANNELS-1:0][COND_W-1:0]    pattern_type;
    typedef logic [DEPTH-1:0][CHANNELS-1:0]     buffer_type;

    // Pre-trigger samples written before the trigger may fire; the
    // trigger sample itself is the last of the pre-trigger share
    localparam index_type PRE_FILL_LAST = index_type'(PRE_COUNT - 2);
    // Samples still to be written after the trigger sample
    localparam index_type POST_LAST     = index_type'(POST_COUNT - 1);
    localparam index_type INDEX_ZERO    = 7'h00;
    localparam index_type INDEX_ONE     = 7'h01;

    // Per-channel trigger condition codes
    localparam cond_type COND_IGNORE  = 3'h0;
    localparam cond_type COND_LOW     = 3'h1;
    localparam cond_type COND_HIGH    = 3'h2;
    localparam cond_type COND_RISE    = 3'h3;
    localparam cond_type COND_FALL    = 3'h4;
    localparam cond_type COND_EITHER  = 3'h5;

    // Reset value of the comparison register: every channel ignored
    localparam pattern_type PATTERN_RESET = '0;

    // Capture sequencer states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_FILL  = 5'h02,
        ST_ARMED = 5'h04,
        ST_POST  = 5'h08,
        ST_DONE  = 5'h10
    } cap_state_type;

endpackage : analyzer_pkg

//--- probe_source.sv
// Model of the monitored nodes of the logic under debug
`timescale 1ns/10ps
`default_nettype none
module probe_source (
    input  wire logic                    sample_clk,
    output var analyzer_pkg::sample_type probe
);
    import analyzer_pkg::*;
    logic [7:0] count = 8'h00;
    // Free-running count; wraps so any value recurs every 256 samples
    always @(posedge sample_clk) begin
        count <= count + 8'h01;
    end
    // Every node on its own channel, count repeated over all 128
    assign probe = {16{count}};
endmodule : probe_source
`default_nettype wire

//--- tb.sv
// Testbench for the trigger capture analyzer
`timescale 1ns/10ps
`default_nettype none
module tb;
    import analyzer_pkg::*;
    logic       ref_clk = 1'b0;
    logic       sample_clk = 1'b0;
    logic       srst = 1'b1;
    logic       acquire = 1'b0;
    logic       cfg_write = 1'b0;
    index_type  cfg_channel = INDEX_ZERO;
    cond_type   cfg_cond = COND_IGNORE;
    logic       read_req = 1'b0;
    index_type  read_index = INDEX_ZERO;
    sample_type probe;
    sample_type read_data;
    logic       read_valid;
    logic       capture_busy;
    logic       capture_done;
    int         errors = 0;
    int         compares = 0;

    // Host clock, 10 ns period
    always #5 ref_clk = ~ref_clk;
    // Link clock, 15 ns, offset so edges never meet the host clock
    initial begin
        #3.3;
        forever #7.5 sample_clk = ~sample_clk;
    end

    probe_source probe_source_i (.sample_clk(sample_clk), .probe(probe));
    trigger_capture_analyzer trigger_capture_analyzer_i (
        .ref_clk(ref_clk), .srst(srst), .sample_clk(sample_clk),
        .probe(probe), .acquire(acquire), .cfg_write(cfg_write),
        .cfg_channel(cfg_channel), .cfg_cond(cfg_cond),
        .read_req(read_req), .read_index(read_index),
        .read_data(read_data), .read_valid(read_valid),
        .capture_busy(capture_busy), .capture_done(capture_done));

    task automatic check(input string what, input sample_type seen,
                         input sample_type exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    task automatic do_reset();
        srst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        check("capture_busy", capture_busy, '0);
        check("capture_done", capture_done, '0);
        check("read_data", read_data, '0);
        srst <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask : do_reset

    // Levels on channels 0..7 match n; one override on 0, one extra
    // channel, and channel 100 given an unused code that must ignore
    task automatic set_pattern(input logic [7:0] n, input cond_type c0,
                               input int chx, input cond_type cx);
        cond_type  c;
        index_type where;
        cfg_write <= 1'b1;
        for (int ch = 0; ch < 10; ch++) begin
            where = index_type'(ch);
            c = n[ch[2:0]] ? COND_HIGH : COND_LOW;
            if (ch == 0 && c0 != COND_IGNORE)
                c = c0;
            if (ch == 8)
                where = index_type'(chx);
            if (ch == 8)
                c = cx;
            if (ch == 9)
                where = 7'h64;
            if (ch == 9)
                c = 3'h7;
            cfg_channel <= where;
            cfg_cond    <= c;
            @(posedge ref_clk);
        end
        cfg_write <= 1'b0;
    endtask : set_pattern

    task automatic capture(input int limit, input logic done_exp);
        acquire <= 1'b1;
        @(posedge ref_clk);
        acquire <= 1'b0;
        @(posedge ref_clk);
        check("capture_busy", capture_busy, 1);
        for (int i = 0; i < limit && capture_done !== 1'b1; i++)
            @(posedge ref_clk);
        check("capture_done", capture_done, done_exp);
    endtask : capture

    // Whole window: trigger sample at 112, oldest at 0
    task automatic window(input logic [7:0] n);
        logic [7:0] v;
        for (int k = 0; k < 128; k++) begin
            v = n + 8'(k) - 8'h70;
            read_index <= index_type'(k);
            read_req   <= 1'b1;
            @(posedge ref_clk);
            read_req   <= 1'b0;
            for (int i = 0; i < 40 && read_valid !== 1'b1; i++)
                @(posedge ref_clk);
            check("read_valid", read_valid, 1);
            check("read_data", read_data, {16{v}});
        end
    endtask : window

    initial begin
        do_reset();
        set_pattern(8'h35, COND_IGNORE, 100, 3'h7);
        capture(1000, 1'b1);
        window(8'h35);
        set_pattern(8'h41, COND_RISE, 100, 3'h7);
        capture(1000, 1'b1);
        window(8'h41);
        set_pattern(8'h58, COND_FALL, 10, COND_EITHER);
        capture(1000, 1'b1);
        window(8'h58);
        // Rise on bit 0 and fall on bit 1 never coincide
        set_pattern(8'h41, COND_RISE, 9, COND_FALL);
        capture(700, 1'b0);
        // Write while busy must be refused; taken, it fires on count 34h
        set_pattern(8'h34, COND_IGNORE, 9, COND_FALL);
        repeat (700) @(posedge ref_clk);
        check("capture_done", capture_done, '0);
        do_reset();
        capture(260, 1'b1);
        complete_run();
    end

    // Hang guard, several times the expected run of about 6300 cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
endmodule : tb
`default_nettype wire

//--- toggle_link_if.sv
// Interface carrying one toggle event across a clock boundary
`timescale 1ns/10ps
`default_nettype none

interface toggle_link_if;
    logic toggle;
    logic pulse;

    modport source (output toggle);
    modport sink   (input toggle, output pulse);
endinterface : toggle_link_if

`default_nettype wire

//--- toggle_sync.sv
// Two-flop toggle synchroniser turning a far-side toggle into a pulse
`timescale 1ns/10ps
`default_nettype none

module toggle_sync (
    input  wire logic      clk,
    input  wire logic      rst,
    toggle_link_if.sink    link
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } sync_state_type;

    sync_state_type s;
    sync_state_type next_s;

    // Only the second flop and its delayed copy feed the edge detect
    always_comb begin
        next_s        = s;
        next_s.meta   = link.toggle;
        next_s.stable = s.meta;
        next_s.last   = s.stable;
        if (rst) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // One pulse per toggle seen on the far side
    assign link.pulse = s.stable ^ s.last;

endmodule : toggle_sync

`default_nettype wire

//--- trigger_capture_analyzer.sv
// Embedded logic analyzer: trigger evaluation, capture buffer, readout
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - All channels are sampled on the single sample_clk, no other domain.
// - One to 128 probe channels, each on its own capture input bit.
// - Buffer stores 128 samples for every probe channel.
// - Window keeps 88 percent pre-trigger and 12 percent post-trigger samples.
// - Trigger compares live probes against the programmed comparison register.
// - Per channel: ignore, low, high, rising, falling or either edge.
// - Every channel condition resets to ignore, masking it from matching.
// - Trigger fires only when all unmasked channels match in one sample.
// - Acquire starts sampling, then capture waits for the trigger.
// - Completed capture is readable sample by sample by the host.

module trigger_capture_analyzer (
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    input  wire logic                      sample_clk,
    input  wire analyzer_pkg::sample_type  probe,
    input  wire logic                      acquire,
    input  wire logic                      cfg_write,
    input  wire analyzer_pkg::index_type   cfg_channel,
    input  wire analyzer_pkg::cond_type    cfg_cond,
    input  wire logic                      read_req,
    input  wire analyzer_pkg::index_type   read_index,
    output var analyzer_pkg::sample_type   read_data,
    output logic                           read_valid,
    output logic                           capture_busy,
    output logic                           capture_done
);
    import analyzer_pkg::*;

    // Host-facing state on ref_clk
    typedef struct packed {
        pattern_type pattern;
        logic        busy;
        logic        done;
        logic        start_tog;
        logic        read_tog;
        logic        read_pend;
        index_type   read_index;
        sample_type  read_data;
        logic        read_valid;
    } host_state_type;

    // Capture-side state on sample_clk
    typedef struct packed {
        logic          rst_meta;
        logic          rst_sync;
        cap_state_type state;
        index_type     wptr;
        index_type     fill_cnt;
        index_type     post_cnt;
        index_type     oldest;
        sample_type    prev;
        logic          done_tog;
        logic          ack_tog;
        sample_type    read_word;
        buffer_type    mem;
    } cap_reg_type;

    // Registered state of each domain and its next value
    host_state_type r;
    host_state_type next_r;
    cap_reg_type    s;
    cap_reg_type    next_s;

    // One link per event that crosses between the clocks
    toggle_link_if  start_link();
    toggle_link_if  read_link();
    toggle_link_if  done_link();
    toggle_link_if  ack_link();

    // Wrapping buffer index arithmetic
    function automatic index_type idx_add(
        input index_type a,
        input index_type b
    );
        idx_add = index_type'(a + b);
    endfunction : idx_add

    // One channel against its condition; unknown codes act as ignore
    function automatic logic cond_match(
        input logic     cur,
        input logic     last,
        input cond_type cond
    );
        unique case (cond)
            COND_IGNORE: cond_match = 1'b1;
            COND_LOW:    cond_match = ~cur;
            COND_HIGH:   cond_match = cur;
            COND_RISE:   cond_match = cur & ~last;
            COND_FALL:   cond_match = ~cur & last;
            COND_EITHER: cond_match = cur ^ last;
            default:     cond_match = 1'b1;
        endcase
    endfunction : cond_match

    // All channels must hold their condition in the same sample
    function automatic logic pattern_match(
        input sample_type  cur,
        input sample_type  last,
        input pattern_type pat
    );
        logic all_ok;
        all_ok = 1'b1;
        for (int i = 0; i < CHANNELS; i++) begin
            all_ok = all_ok & cond_match(cur[i], last[i], pat[i]);
        end
        pattern_match = all_ok;
    endfunction : pattern_match

    // Event crossings between the two clocks
    assign start_link.toggle = r.start_tog;
    assign read_link.toggle  = r.read_tog;
    assign done_link.toggle  = s.done_tog;
    assign ack_link.toggle   = s.ack_tog;

    // Requests from the host into the capture clock
    toggle_sync start_sync (
        .clk  (sample_clk),
        .rst  (s.rst_sync),
        .link (start_link)
    );

    toggle_sync read_sync (
        .clk  (sample_clk),
        .rst  (s.rst_sync),
        .link (read_link)
    );

    // Answers from the capture side back to the host
    toggle_sync done_sync (
        .clk  (ref_clk),
        .rst  (srst),
        .link (done_link)
    );

    toggle_sync ack_sync (
        .clk  (ref_clk),
        .rst  (srst),
        .link (ack_link)
    );

    // Host side: configuration, arming and readout handshakes
    always_comb begin
        next_r            = r;
        // Strobe, low unless a read answer lands
        next_r.read_valid = 1'b0;

        // Capture finished on the far side
        if (done_link.pulse) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
        end

        // Pattern is frozen while a capture runs, since the sample
        // side reads it directly as a quasi-static word
        if (cfg_write && !r.busy) begin
            next_r.pattern[cfg_channel] = cfg_cond;
        end

        // Arm a new capture; old contents are lost from here on
        if (acquire && !r.busy && !r.read_pend) begin
            next_r.busy      = 1'b1;
            next_r.done      = 1'b0;
            next_r.start_tog = ~r.start_tog;
        end

        // One readout request at a time, only on a finished capture
        if (read_req && r.done && !r.busy && !r.read_pend) begin
            next_r.read_pend  = 1'b1;
            next_r.read_index = read_index;
            next_r.read_tog   = ~r.read_tog;
        end

        // Word is loaded on the far side in the same cycle its ack toggles, stable before this pulse
        if (ack_link.pulse) begin
            next_r.read_pend  = 1'b0;
            next_r.read_data  = s.read_word;
            next_r.read_valid = 1'b1;
        end

        // Reset wins over every request in the same cycle
        if (srst) begin
            next_r            = '0;
            next_r.pattern    = PATTERN_RESET;
        end
    end

    // Host register stage
    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    // Capture side: sequencer, circular buffer and readout port
    always_comb begin
        logic write_en;
        // Buffer write strobe for this sample
        write_en      = 1'b0;
        next_s        = s;
        // Previous sample for the edge conditions
        next_s.prev   = probe;

        // Capture sequencer
        unique case (s.state)
            ST_IDLE: begin
                // Wait for an arm request from the host
                if (start_link.pulse) begin
                    next_s.state    = ST_FILL;
                    next_s.wptr     = INDEX_ZERO;
                    next_s.fill_cnt = INDEX_ZERO;
                end
            end
            ST_FILL: begin
                // Gather the pre-trigger share before arming
                write_en = 1'b1;
                if (s.fill_cnt == PRE_FILL_LAST) begin
                    next_s.state = ST_ARMED;
                end else begin
                    next_s.fill_cnt = idx_add(s.fill_cnt, INDEX_ONE);
                end
            end
            ST_ARMED: begin
                // Keep overwriting the oldest sample until a match
                write_en = 1'b1;
                if (pattern_match(probe, s.prev, r.pattern)) begin
                    next_s.state    = ST_POST;
                    next_s.post_cnt = POST_LAST;
                end
            end
            ST_POST: begin
                // Post-trigger share, then hand the window over
                write_en = 1'b1;
                if (s.post_cnt == INDEX_ZERO) begin
                    next_s.state    = ST_DONE;
                    next_s.oldest   = idx_add(s.wptr, INDEX_ONE);
                    next_s.done_tog = ~s.done_tog;
                end else begin
                    next_s.post_cnt = idx_add(s.post_cnt, 7'h7F);
                end
            end
            ST_DONE: begin
                // Window held for readout until re-armed
                if (start_link.pulse) begin
                    next_s.state    = ST_FILL;
                    next_s.wptr     = INDEX_ZERO;
                    next_s.fill_cnt = INDEX_ZERO;
                end
            end
            default: begin
                // Upset or unreset code falls back to idle
                next_s.state = ST_IDLE;
            end
        endcase

        // Every probe bit is stored each sample_clk while capturing
        if (write_en) begin
            next_s.mem[s.wptr] = probe;
            next_s.wptr        = idx_add(s.wptr, INDEX_ONE);
        end

        // Readout index counts from the oldest stored sample
        if (read_link.pulse) begin
            next_s.read_word = s.mem[idx_add(s.oldest, r.read_index)];
            next_s.ack_tog   = ~s.ack_tog;
        end

        // Reset is brought in through two flops; the buffer keeps data
        next_s.rst_meta = srst;
        next_s.rst_sync = s.rst_meta;
        // Synchronised reset overrides every branch above
        if (s.rst_sync) begin
            next_s.state    = ST_IDLE;
            next_s.wptr     = INDEX_ZERO;
            next_s.fill_cnt = INDEX_ZERO;
            next_s.post_cnt = INDEX_ZERO;
            next_s.oldest   = INDEX_ZERO;
            next_s.prev     = '0;
            next_s.done_tog = 1'b0;
            next_s.ack_tog  = 1'b0;
            next_s.read_word = '0;
        end
    end

    // Capture register stage, buffer included
    always_ff @(posedge sample_clk) begin
        s <= next_s;
    end

    // Outputs straight from host-side flops
    assign read_data    = r.read_data;
    assign read_valid   = r.read_valid;
    assign capture_busy = r.busy;
    assign capture_done = r.done;

endmodule : trigger_capture_analyzer

`default_nettype wire
